// ### sgw_ahb_port.sv
`timescale 1ns/1ps
module sgw_ahb_port (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // register side
    input  wire logic [31:0] rd_data,
    output logic             wr_stb,
    output logic             rd_stb,
    output logic [7:0]       acc_addr,
    output logic [2:0]       acc_size,
    output logic             acc_lane0
);
    sgw_pkg::sgw_state_t state;
    sgw_pkg::sgw_state_t next_state;
    logic [7:0]  next_addr;
    logic [2:0]  next_size;
    logic        next_ready;
    logic [31:0] next_rdata;
    logic        take;

    // reads get one wait so the data word is a flop and sees the prior write
    assign take      = hsel && hready && (htrans == sgw_pkg::HTRANS_NSEQ);
    assign wr_stb    = (state == sgw_pkg::ST_WDATA);
    assign rd_stb    = (state == sgw_pkg::ST_RWAIT);
    assign acc_lane0 = (acc_addr[1:0] == 2'h0);

    always_comb begin
        next_state = state;
        next_addr  = acc_addr;
        next_size  = acc_size;
        next_ready = 1'b1;
        next_rdata = hrdata;
        case (state)
            sgw_pkg::ST_RWAIT: begin
                next_rdata = rd_data;
                next_state = sgw_pkg::ST_RDONE;
            end
            default: begin
                next_state = sgw_pkg::ST_IDLE;
                if (take) begin
                    next_addr  = haddr[7:0];
                    next_size  = hsize;
                    next_ready = hwrite;
                    next_state = hwrite ? sgw_pkg::ST_WDATA : sgw_pkg::ST_RWAIT;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state     <= sgw_pkg::ST_IDLE;
            acc_addr  <= 8'h00;
            acc_size  <= 3'h0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h0000_0000;
        end else begin
            state     <= next_state;
            acc_addr  <= next_addr;
            acc_size  <= next_size;
            hreadyout <= next_ready;
            hresp     <= sgw_pkg::HRESP_OKAY[0];
            hrdata    <= next_rdata;
        end
    end
endmodule : sgw_ahb_port

// ### sgw_cpu_model.sv
`timescale 1ns/1ps
module sgw_cpu_model (
    // clock
    input  wire logic        clk,
    // ahb-lite master
    output logic             hsel,
    output logic [31:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata
);
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0000_0000;
    end

    // entered just after an edge; returns settled just after the closing edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [2:0] sz,
                        input logic [31:0] d, output logic [31:0] q);
        hsel <= 1'b1;
        htrans <= sgw_pkg::HTRANS_NSEQ;
        haddr <= {24'h00_0000, a};
        hwrite <= w;
        hsize <= sz;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        // a read drives the complement of the data already on the bus
        hwdata <= w ? d : ~hwdata;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        q = hrdata;
        #1;
    endtask : xfer

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [2:0] sz);
        logic [31:0] q;
        xfer(1'b1, a, sz, {24'h00_0000, d}, q);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 3'h2, 32'h0000_0000, q);
    endtask : rd

    // full unlock sequence as software runs it
    task automatic unlock(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] saved;
        logic [31:0] q;
        rd(sgw_pkg::OFS_DMA, saved);
        wr(sgw_pkg::OFS_DMA, saved[7:0] & 8'hFE, sgw_pkg::SIZE_BYTE);
        wr(sgw_pkg::OFS_CMD, d, sgw_pkg::SIZE_BYTE);
        wr(a, d, sgw_pkg::SIZE_BYTE);
        // idle cycles stand in for the settling instructions
        repeat (5) @(posedge clk);
        rd(sgw_pkg::OFS_DMA, q);
        if (q[7] === 1'b0) wr(sgw_pkg::OFS_DMA, saved[7:0], sgw_pkg::SIZE_BYTE);
    endtask : unlock
endmodule : sgw_cpu_model

// ### sgw_guard.sv
// The address map and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - exactly six registers are protected: power, cpu clock, watchdog, clock monitor, reset, voltage
// - protected writes only land via the unlock sequence; breaks are flagged in status
// - unlocking write may be store, bit set, bit clear or bit invert
// - transfer complete clears on read and ignores writes of zero
// - protected registers read freely without any unlock
// - transfer complete sits at bit 7 of dma channel control
// - only a protected write that is the next write after a command write takes effect
// - command register takes byte writes only and reads as zero
// - error on unarmed protected write or armed write to another register
// - error clears on zero write or reset; zero write after command wins
module sgw_guard (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_b,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // dma channel
    input  wire logic        transfer_done,
    output logic             dma_enable,
    output logic             transfer_complete_flag,
    // guarded system settings
    output logic [7:0]       power_save_control,
    output logic [7:0]       processor_clock_control,
    output logic [7:0]       watchdog_mode,
    output logic [7:0]       clock_monitor_mode,
    output logic [7:0]       reset_source_flags,
    output logic [7:0]       low_voltage_detection_mode,
    output logic             standby_entry_bit,
    output logic             protection_error_flag
);
    logic                   wr_stb;
    logic                   rd_stb;
    logic [7:0]             acc_addr;
    logic [2:0]             acc_size;
    logic                   acc_lane0;
    logic [31:0]            rd_data;
    logic [sgw_pkg::PROT_NUM*8-1:0] prot_flat;
    logic                   armed;
    logic                   next_armed;
    logic                   next_err;
    logic                   prot_wr;
    logic                   next_dma_en;
    logic                   next_tc;
    logic                   is_cmd;
    logic                   is_sys;
    logic                   is_dma;
    logic                   in_prot;
    logic                   is_prot;
    logic                   cmd_byte;
    logic [2:0]             prot_idx;
    sgw_pkg::sgw_op_t       prot_op;
    logic [7:0]             prot_sel;

    sgw_ahb_port u_port (
        .clk       (clk),
        .rst_b     (rst_b),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hresp     (hresp),
        .hrdata    (hrdata),
        .rd_data   (rd_data),
        .wr_stb    (wr_stb),
        .rd_stb    (rd_stb),
        .acc_addr  (acc_addr),
        .acc_size  (acc_size),
        .acc_lane0 (acc_lane0)
    );

    sgw_prot_bank #(
        .N (sgw_pkg::PROT_NUM)
    ) u_bank (
        .clk     (clk),
        .rst_b   (rst_b),
        .wr_en   (prot_wr),
        .wr_idx  (prot_idx),
        .wr_op   (prot_op),
        .wr_data (hwdata[7:0]),
        .regs    (prot_flat)
    );

    // decode; only the low address byte is decoded, so the map aliases
    assign is_cmd   = (acc_addr[7:2] == sgw_pkg::OFS_CMD[7:2]);
    assign is_sys   = (acc_addr[7:2] == sgw_pkg::OFS_SYS[7:2]);
    assign is_dma   = (acc_addr[7:2] == sgw_pkg::OFS_DMA[7:2]);
    assign prot_idx = acc_addr[4:2];
    assign prot_op  = sgw_pkg::sgw_op_t'(acc_addr[6:5]);
    assign in_prot  = !acc_addr[7] && (prot_idx < 3'(sgw_pkg::PROT_NUM));
    assign is_prot  = in_prot && acc_lane0;
    assign cmd_byte = is_cmd && (acc_size == sgw_pkg::SIZE_BYTE);
    assign prot_sel = prot_flat[8*prot_idx +: 8];

    assign power_save_control         = prot_flat[8*sgw_pkg::IDX_PWR_SAVE +: 8];
    assign processor_clock_control    = prot_flat[8*sgw_pkg::IDX_CPU_CLK +: 8];
    assign watchdog_mode              = prot_flat[8*sgw_pkg::IDX_WDOG +: 8];
    assign clock_monitor_mode         = prot_flat[8*sgw_pkg::IDX_CLK_MON +: 8];
    assign reset_source_flags         = prot_flat[8*sgw_pkg::IDX_RST_SRC +: 8];
    assign low_voltage_detection_mode = prot_flat[8*sgw_pkg::IDX_LOW_VOLT +: 8];
    assign standby_entry_bit          = power_save_control[sgw_pkg::STANDBY_BIT];

    // guard: reads never disturb the armed state, so a load may sit between
    always_comb begin
        next_armed = armed;
        next_err   = protection_error_flag;
        prot_wr    = 1'b0;
        if (wr_stb) begin
            next_armed = 1'b0;
            if (cmd_byte) begin
                next_armed = 1'b1;
                if (armed) begin
                    next_err = 1'b1;
                end
            end else if (is_prot) begin
                if (armed) begin
                    prot_wr = 1'b1;
                end else begin
                    next_err = 1'b1;
                end
            end else if (is_sys && acc_lane0 && !hwdata[sgw_pkg::ERR_BIT]) begin
                next_err = 1'b0;
            end else if (armed) begin
                next_err = 1'b1;
            end
        end
    end

    // dma channel control; completion wins over a read-clear in the same cycle
    always_comb begin
        next_dma_en = dma_enable;
        next_tc     = transfer_complete_flag;
        if (wr_stb && is_dma && acc_lane0) begin
            next_dma_en = hwdata[sgw_pkg::DMA_EN_BIT];
        end
        if (rd_stb && is_dma) begin
            next_tc = 1'b0;
        end
        if (transfer_done) begin
            next_tc     = 1'b1;
            next_dma_en = 1'b0;
        end
    end

    // read mux; command register has no readable state
    always_comb begin
        rd_data = sgw_pkg::RD_ZERO;
        if (in_prot) begin
            rd_data[7:0] = prot_sel;
        end else if (is_sys) begin
            rd_data[sgw_pkg::ERR_BIT] = protection_error_flag;
        end else if (is_dma) begin
            rd_data[sgw_pkg::TC_BIT]     = transfer_complete_flag;
            rd_data[sgw_pkg::DMA_EN_BIT] = dma_enable;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            armed                  <= 1'b0;
            protection_error_flag  <= 1'b0;
            dma_enable             <= 1'b0;
            transfer_complete_flag <= 1'b0;
        end else begin
            armed                  <= next_armed;
            protection_error_flag  <= next_err;
            dma_enable             <= next_dma_en;
            transfer_complete_flag <= next_tc;
        end
    end

    // checks
    logic [2:0] h_idx;
    logic [7:0] h_view;
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            h_idx <= 3'h0;
        end else if (wr_stb) begin
            h_idx <= prot_idx;
        end
    end
    assign h_view = prot_flat[8*h_idx +: 8];

    sequence s_arm;
        wr_stb && cmd_byte;
    endsequence
    sequence s_hit;
        wr_stb && is_prot;
    endsequence

    AST_ONLY_SIX: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_stb && !acc_addr[7] && !in_prot) |=> $stable(prot_flat))
        else $error("write outside six protected slots changed one");
    AST_UNARMED_REJECT: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_stb && is_prot && !armed) |=> (protection_error_flag && $stable(prot_flat)))
        else $error("unarmed protected write landed or was not flagged");
    AST_INVERT_FORM: assert property (@(posedge clk) disable iff (!rst_b)
        (s_hit and (armed && prot_op == sgw_pkg::OP_INVERT))
        |=> (h_view == ($past(prot_sel) ^ $past(hwdata[7:0]))))
        else $error("armed invert write gave wrong value");
    AST_ONE_SHOT: assert property (@(posedge clk) disable iff (!rst_b)
        (s_hit and armed) |=> !armed)
        else $error("guard stayed armed after protected write");
    AST_SECOND_HIT: assert property (@(posedge clk) disable iff (!rst_b)
        ((s_hit and armed) ##1 !wr_stb ##1 s_hit) |=> (protection_error_flag && $stable(prot_flat)))
        else $error("second protected write not flagged");
    AST_CMD_BYTE: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_stb && is_cmd && acc_size != sgw_pkg::SIZE_BYTE) |=> !armed)
        else $error("wide command write armed the guard");
    AST_ARM: assert property (@(posedge clk) disable iff (!rst_b)
        s_arm |=> armed ##1 (armed || $past(wr_stb)))
        else $error("command write did not arm until next write");
    AST_STRAY: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_stb && armed && !is_prot && !is_cmd && !is_sys) |=> protection_error_flag)
        else $error("armed stray write not flagged");
    AST_ZERO_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_stb && is_sys && acc_lane0 && !hwdata[sgw_pkg::ERR_BIT]) |=> !protection_error_flag)
        else $error("zero write did not clear error flag");
    AST_TC_READ: assert property (@(posedge clk) disable iff (!rst_b)
        (rd_stb && is_dma && !transfer_done) |=> !transfer_complete_flag)
        else $error("read did not clear transfer complete");
    AST_TC_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
        (wr_stb && transfer_complete_flag && !rd_stb) |=> transfer_complete_flag)
        else $error("write cleared transfer complete");
    AST_TC_BIT: assert property (@(posedge clk) disable iff (!rst_b)
        (rd_stb && is_dma) |=> (hrdata[7] == $past(transfer_complete_flag)))
        else $error("transfer complete not at bit 7");
    AST_FREE_READ: assert property (@(posedge clk) disable iff (!rst_b)
        (rd_stb && in_prot) |=> (hrdata[7:0] == $past(prot_sel) && armed == $past(armed)))
        else $error("protected read wrong or disturbed guard");
endmodule : sgw_guard

// ### sgw_pkg.sv
package sgw_pkg;
    // protected registers, one aligned word each
    localparam int        PROT_NUM     = 6;
    localparam logic [2:0] IDX_PWR_SAVE = 3'h0;
    localparam logic [2:0] IDX_CPU_CLK  = 3'h1;
    localparam logic [2:0] IDX_WDOG     = 3'h2;
    localparam logic [2:0] IDX_CLK_MON  = 3'h3;
    localparam logic [2:0] IDX_RST_SRC  = 3'h4;
    localparam logic [2:0] IDX_LOW_VOLT = 3'h5;
    localparam logic [7:0] PROT_RST     = 8'h00;
    // other registers
    localparam logic [7:0] OFS_CMD      = 8'h80;
    localparam logic [7:0] OFS_SYS      = 8'h84;
    localparam logic [7:0] OFS_DMA      = 8'h88;
    localparam int        ERR_BIT      = 0;
    localparam int        DMA_EN_BIT   = 0;
    localparam int        TC_BIT       = 7;
    localparam int        STANDBY_BIT  = 1;
    // bus encodings
    localparam logic [2:0] SIZE_BYTE    = 3'h0;
    localparam logic [1:0] HTRANS_NSEQ  = 2'h2;
    localparam logic [1:0] HRESP_OKAY   = 2'h0;
    localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

    // address bits [6:5] of a protected access pick the write form
    typedef enum logic [1:0] {
        OP_STORE,
        OP_SET,
        OP_CLEAR,
        OP_INVERT
    } sgw_op_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WDATA,
        ST_RWAIT,
        ST_RDONE
    } sgw_state_t;
endpackage : sgw_pkg

// ### sgw_prot_bank.sv
`timescale 1ns/1ps
module sgw_prot_bank #(
    parameter int N = 6
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst_b,
    // accepted write
    input  wire logic           wr_en,
    input  wire logic [2:0]     wr_idx,
    input  wire sgw_pkg::sgw_op_t wr_op,
    input  wire logic [7:0]     wr_data,
    // register contents
    output logic [N*8-1:0]      regs
);
    logic [N*8-1:0] next_regs;

    always_comb begin
        next_regs = regs;
        for (int i = 0; i < N; i++) begin
            if (wr_en && (wr_idx == 3'(i))) begin
                case (wr_op)
                    sgw_pkg::OP_SET:    next_regs[i*8 +: 8] = regs[i*8 +: 8] | wr_data;
                    sgw_pkg::OP_CLEAR:  next_regs[i*8 +: 8] = regs[i*8 +: 8] & ~wr_data;
                    sgw_pkg::OP_INVERT: next_regs[i*8 +: 8] = regs[i*8 +: 8] ^ wr_data;
                    default:            next_regs[i*8 +: 8] = wr_data;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            regs <= {N{sgw_pkg::PROT_RST}};
        end else begin
            regs <= next_regs;
        end
    end
endmodule : sgw_prot_bank

// ### tb.sv
`timescale 1ns/1ps
module tb;
    logic        clk;
    logic        rst_b;
    logic        transfer_done;
    logic        hsel, hwrite, hready, hresp, dma_en, tc, stby, err;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  r0, r1, r2, r3, r4, r5;
    logic [7:0]  exp_r [6];
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;

    sgw_cpu_model i_sgw_cpu_model (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

    sgw_guard i_sgw_guard (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .transfer_done(transfer_done),
        .dma_enable(dma_en), .transfer_complete_flag(tc), .power_save_control(r0),
        .processor_clock_control(r1), .watchdog_mode(r2), .clock_monitor_mode(r3),
        .reset_source_flags(r4), .low_voltage_detection_mode(r5),
        .standby_entry_bit(stby), .protection_error_flag(err));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // hangs are cut short well beyond the few hundred cycles the run needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            num_errors++;
            conclude();
        end
    end

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk

    task automatic chk_regs();
        logic [7:0] g [6];
        g = '{r0, r1, r2, r3, r4, r5};
        for (int i = 0; i < 6; i++) chk($sformatf("reg%0d", i), exp_r[i], g[i]);
    endtask : chk_regs

    task automatic wrb(logic [7:0] a, logic [7:0] d);
        i_sgw_cpu_model.wr(a, d, sgw_pkg::SIZE_BYTE);
    endtask : wrb

    initial begin
        rst_b = 1'b0;
        transfer_done = 1'b0;
        exp_r = '{default: 8'h00};
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        chk_regs();
        chk("err", 0, err);
        for (int i = 0; i < 6; i++) begin
            exp_r[i] = 8'(8'h11 * (i + 1));
            i_sgw_cpu_model.unlock(8'(i * 4), exp_r[i]);
        end
        chk_regs();
        for (int i = 0; i < 6; i++) begin
            i_sgw_cpu_model.rd(8'(i * 4), q);
            chk("readback", {24'h0, exp_r[i]}, q);
        end
        i_sgw_cpu_model.unlock(8'h20, 8'h02);
        exp_r[0] |= 8'h02;
        chk("standby", 1, stby);
        i_sgw_cpu_model.unlock(8'h40, 8'h01);
        exp_r[0] &= ~8'h01;
        i_sgw_cpu_model.unlock(8'h60, 8'hFF);
        exp_r[0] ^= 8'hFF;
        chk_regs();
        i_sgw_cpu_model.wr(8'h08, 8'hAA, 3'h2);
        chk_regs();
        chk("err", 1, err);
        wrb(8'h84, 8'h01);
        chk("err", 1, err);
        wrb(8'h84, 8'h00);
        chk("err", 0, err);
        wrb(8'h80, 8'h00);
        wrb(8'h08, 8'h5A);
        wrb(8'h08, 8'hA5);
        exp_r[2] = 8'h5A;
        chk_regs();
        chk("err", 1, err);
        wrb(8'h84, 8'h00);
        wrb(8'h80, 8'h00);
        wrb(8'h88, 8'h00);
        chk("err", 1, err);
        wrb(8'h0C, 8'h77);
        chk_regs();
        wrb(8'h84, 8'h00);
        wrb(8'h80, 8'h00);
        wrb(8'h84, 8'h00);
        chk("err", 0, err);
        wrb(8'h80, 8'h00);
        wrb(8'h80, 8'h00);
        chk("err", 1, err);
        wrb(8'h10, 8'h3C);
        exp_r[4] = 8'h3C;
        chk_regs();
        wrb(8'h84, 8'h00);
        wrb(8'h80, 8'h00);
        i_sgw_cpu_model.rd(8'h80, q);
        chk("cmd read", 0, q);
        wrb(8'h14, 8'h42);
        exp_r[5] = 8'h42;
        chk_regs();
        i_sgw_cpu_model.wr(8'h80, 8'h00, 3'h2);
        wrb(8'h14, 8'h99);
        chk_regs();
        chk("err", 1, err);
        wrb(8'h84, 8'h00);
        wrb(8'h88, 8'h01);
        chk("dma_en", 1, dma_en);
        transfer_done <= 1'b1;
        @(posedge clk);
        transfer_done <= 1'b0;
        @(posedge clk);
        #1;
        chk("tc", 1, tc);
        chk("dma_en", 0, dma_en);
        wrb(8'h88, 8'h00);
        chk("tc", 1, tc);
        i_sgw_cpu_model.rd(8'h88, q);
        chk("tc bit", 1, q[7]);
        chk("tc", 0, tc);
        i_sgw_cpu_model.rd(8'h88, q);
        chk("tc bit", 0, q[7]);
        chk("hresp", sgw_pkg::HRESP_OKAY, hresp);
        wrb(8'h80, 8'h00);
        wrb(8'h18, 8'hCC);
        chk_regs();
        chk("err", 1, err);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        exp_r = '{default: 8'h00};
        chk_regs();
        chk("err", 0, err);
        chk("tc", 0, tc);
        conclude();
    end
endmodule : tb
